/* design/fwad_pkg.sv */
// Package: constants and types for the flash window address decoder
package fwad_pkg;
    // Window geometry
    localparam int unsigned WIN_AW        = 13;            // 8KB window, byte offset width
    localparam int unsigned SEC_AW        = 11;            // 2KB section, in-section offset width
    localparam int unsigned BOOT_AW       = 10;            // 1KB boot code per die
    localparam logic [1:0]  SEC_BOOT_LO   = 2'h0;
    localparam logic [1:0]  SEC_REG_LO    = 2'h1;
    localparam logic [1:0]  SEC_REG_HI    = 2'h2;
    localparam logic [1:0]  SEC_BOOT_HI   = 2'h3;
    // Register offsets, relative to the window base
    localparam logic [12:0] OFS_IDENTITY  = 13'h1000;
    localparam logic [12:0] OFS_IDLE      = 13'h1002;
    localparam logic [12:0] OFS_SCRATCH   = 13'h1004;
    localparam logic [12:0] OFS_MODE_CTL  = 13'h1006;
    localparam logic [12:0] OFS_DIE_SEL   = 13'h1008;
    localparam logic [12:0] OFS_CONFIG    = 13'h100A;
    localparam logic [12:0] OFS_OUT_CTL   = 13'h100C;
    localparam logic [12:0] OFS_IRQ_CTL   = 13'h100E;
    localparam logic [12:0] OFS_TOGGLE    = 13'h1046;
    localparam logic [12:0] OFS_MODE_CFM  = 13'h1076;
    // Identity value: arbitrary neutral value
    localparam logic [7:0]  IDENTITY_VAL  = 8'hA5;
    // Read data constants
    localparam logic [7:0]  RD_ZERO       = 8'h00;
    // Reset values applied on leaving reset mode for normal mode
    localparam logic [7:0]  RST_SCRATCH   = 8'h00;
    localparam logic [7:0]  RST_MODE_CTL  = 8'h10;
    localparam logic [7:0]  RST_DIE_SEL   = 8'h00;
    localparam logic [7:0]  RST_CONFIG    = 8'h00;
    localparam logic [7:0]  RST_OUT_CTL   = 8'h00;
    localparam logic [7:0]  RST_IRQ_CTL   = 8'h00;
    // Mode control field layout
    localparam logic [7:0]  MODE_CTL_RSVD0 = 8'hE0;        // Bits 7..5 read as zero
    localparam int unsigned MODE_LSB       = 0;
    localparam int unsigned MDWREN_BIT     = 2;
    // Configuration: highest die index field
    localparam int unsigned HDI_LSB        = 4;
    localparam logic [7:0]  HDI_MASK       = 8'h30;
    // Operating modes
    localparam logic [1:0]  MODE_RESET     = 2'h0;
    localparam logic [1:0]  MODE_NORMAL    = 2'h1;
    localparam logic [1:0]  MODE_POWERDN   = 2'h2;

    // Host bus request as seen by the decoder
    typedef struct packed {
        logic        rd;                                    // Read strobe, one cycle
        logic        wr;                                    // Write strobe, one cycle
        logic [12:0] ofs;                                   // Offset inside the window
        logic [7:0]  wdata;                                 // Write data
    } fwad_req_t;

    // Read answer
    typedef struct packed {
        logic        valid;                                 // Read data valid, one cycle
        logic [7:0]  data;                                  // Read data
    } fwad_rsp_t;

    // Boot code fetch request to the flash array
    typedef struct packed {
        logic        en;                                    // Fetch enable
        logic        die;                                   // 0 first die, 1 second die
        logic [9:0]  addr;                                  // Byte inside 1KB boot code
    } fwad_boot_t;
endpackage

/* design/fwad_decoder.sv */
// Flash window address decoder and register front end
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1 - Decode 8KB window as four 2KB sections
// RQ2 - Offsets are relative to window base
// RQ3 - Reset mode: 1KB boot code in sections 0,3
// RQ4 - Reset mode: sections 1,2 read 00H
// RQ5 - Normal mode: sections 1,2 map registers
// RQ6 - Dual die reset: first die code only
// RQ7 - Die index written: second alias becomes die two
// RQ8 - Dual normal: section 0 both, 3 first
// RQ9 - Identity register is fixed, read only
// RQ10 - Undefined reserved bits ignore writes
// RQ11 - Reserved-zero bits read zero
// RQ12 - Reserved-one bits read one
// RQ13 - Reset mode: all register reads 00H
// RQ14 - Reset values load on leaving reset mode; code loads them only when leaving for normal mode
// RQ15 - Mode field: 00 reset, 01 normal, 10 power-down
// RQ16 - Mode change needs value then complement
// RQ17 - Section from offset bits 12,11
// RQ18 - Unmatched register offsets ignored on write
module fwad_decoder #(
    parameter bit DUAL_DIE = 1'b0                           // Two-die build
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire fwad_pkg::fwad_req_t req,                   // Host cycle
    input  wire logic [7:0]          boot_rdata,            // Boot code byte from array
    output var  fwad_pkg::fwad_rsp_t rsp,                   // Read answer
    output var  fwad_pkg::fwad_boot_t boot,                 // Boot code fetch
    output var  logic [1:0]          mode,                  // Current operating mode
    output var  logic [7:0]          out_ctl,               // Output pin control value
    output var  logic [7:0]          irq_ctl                // Interrupt control value
);
    // Decode of the incoming cycle; offset is window relative, never absolute
    logic [1:0]  sec;                                       // Section number
    logic [10:0] in_sec;                                    // Offset inside section
    logic        is_boot;                                   // Boot block access
    logic        is_reg;                                    // Register section access
    logic        normal;                                    // Normal mode
    // The normal flag below reads the mode word, so it is declared ahead of it
    logic [1:0]  mode_q;                                    // Operating mode
    assign sec     = req.ofs[12:11];                        // RQ17 RQ1 RQ2
    assign in_sec  = req.ofs[10:0];                         // RQ17
    assign is_boot = (sec == fwad_pkg::SEC_BOOT_LO) || (sec == fwad_pkg::SEC_BOOT_HI); // RQ1
    assign is_reg  = !is_boot;
    assign normal  = (mode_q == fwad_pkg::MODE_NORMAL);

    // Stored registers
    logic [2:0] ctl_q;                                      // Latch, detect, write enable
    logic [7:0] scratch_q;                                  // Scratch value
    logic [7:0] die_sel_q;                                  // Die select
    logic [7:0] cfg_q;                                      // Configuration
    logic [7:0] out_ctl_q;                                  // Output pin control
    logic [7:0] irq_ctl_q;                                  // Interrupt control
    logic       hdi_set_q;                                  // Die index field written
    logic       pend_q;                                     // Control value armed
    logic [7:0] pend_val_q;                                 // Armed control value
    logic       toggle_q;                                   // Progress toggle

    logic wr_reg;                                           // Register write accepted
    // Register writes land only in normal mode; in power-down only the mode pair and the die index flag still act
    // Storing in reset mode would gain nothing: leaving it for normal mode reloads the values
    assign wr_reg = req.wr && is_reg && normal;             // RQ5

    // Mode confirmation: control value, then its complement, no access between
    // except boot block reads. Works from any mode so reset mode can be left.
    always_ff @(posedge clk) begin
        if (srst) begin
            pend_q     <= 1'b0;
            pend_val_q <= 8'h00;
            mode_q     <= fwad_pkg::MODE_RESET;
        end else if (req.wr && req.ofs == fwad_pkg::OFS_MODE_CTL) begin
            // First half: remember the value until its complement arrives
            pend_q     <= 1'b1;                             // RQ16
            pend_val_q <= req.wdata;
        end else if (req.wr && req.ofs == fwad_pkg::OFS_MODE_CFM) begin
            pend_q <= 1'b0;
            // Armed value plus its complement, with mode write enable set
            // Code 11 names no mode and is refused
            if (pend_q && (req.wdata == ~pend_val_q) && pend_val_q[fwad_pkg::MDWREN_BIT]
                && pend_val_q[1:0] != 2'h3) begin
                mode_q <= pend_val_q[1:0];                  // RQ16 RQ15
            end
        end else if (req.wr || (req.rd && !is_boot)) begin
            // Any other write, or a read outside the boot block, breaks the pair
            pend_q <= 1'b0;                                 // RQ16
        end
    end

    // Same test as the confirm branch above, narrowed to reset into normal
    logic leave_reset;                                      // Reset to normal transition
    assign leave_reset = (mode_q == fwad_pkg::MODE_RESET) && req.wr
        && req.ofs == fwad_pkg::OFS_MODE_CFM && pend_q && (req.wdata == ~pend_val_q)
        && pend_val_q[fwad_pkg::MDWREN_BIT] && pend_val_q[1:0] == fwad_pkg::MODE_NORMAL;

    // Host read/write registers; reset values applied at leaving reset mode for normal mode
    always_ff @(posedge clk) begin
        if (srst) begin
            scratch_q <= fwad_pkg::RST_SCRATCH;
            die_sel_q <= fwad_pkg::RST_DIE_SEL;
            cfg_q     <= fwad_pkg::RST_CONFIG;
            out_ctl_q <= fwad_pkg::RST_OUT_CTL;
            irq_ctl_q <= fwad_pkg::RST_IRQ_CTL;
            ctl_q     <= fwad_pkg::RST_MODE_CTL[4:2];
        end else if (leave_reset) begin
            // Documented values take effect on leaving reset mode for normal mode
            scratch_q <= fwad_pkg::RST_SCRATCH;             // RQ14
            die_sel_q <= fwad_pkg::RST_DIE_SEL;
            cfg_q     <= fwad_pkg::RST_CONFIG;
            out_ctl_q <= fwad_pkg::RST_OUT_CTL;
            irq_ctl_q <= fwad_pkg::RST_IRQ_CTL;
            ctl_q     <= fwad_pkg::RST_MODE_CTL[4:2];       // RQ14
        end else if (wr_reg) begin
            // Normal-mode host writes, one register per offset
            case (req.ofs)
                fwad_pkg::OFS_SCRATCH: scratch_q <= req.wdata;
                fwad_pkg::OFS_DIE_SEL: die_sel_q <= req.wdata;
                fwad_pkg::OFS_CONFIG:  cfg_q     <= req.wdata;
                fwad_pkg::OFS_OUT_CTL: out_ctl_q <= req.wdata;
                fwad_pkg::OFS_IRQ_CTL: irq_ctl_q <= req.wdata;
                fwad_pkg::OFS_MODE_CTL: begin
                    // Latch bits clear on write-one; write enable is stored
                    ctl_q[2] <= ctl_q[2] & ~req.wdata[4];
                    ctl_q[1] <= ctl_q[1] & ~req.wdata[3];
                    ctl_q[0] <= req.wdata[2];
                end
                // Identity, idle access and unknown offsets store nothing
                default: ;                                  // RQ18 RQ9 RQ10
            endcase
        end
    end

    // Die index field written flag; reset mode counts too for the boot block swap
    // Cleared only by srst: once chosen, the second image stays mapped
    always_ff @(posedge clk) begin
        if (srst) begin
            hdi_set_q <= 1'b0;
        end else if (req.wr && req.ofs == fwad_pkg::OFS_CONFIG) begin
            hdi_set_q <= 1'b1;                              // RQ7
        end
    end

    // Progress toggle flips on each read of its location
    // Reads in other modes leave it alone, so reset mode reads stay zero
    always_ff @(posedge clk) begin
        if (srst) begin
            toggle_q <= 1'b0;
        end else if (req.rd && normal && req.ofs == fwad_pkg::OFS_TOGGLE) begin
            toggle_q <= ~toggle_q;
        end
    end

    // Register read mux
    // Pure offset decode; the answer path adds the reset-mode zero
    logic [7:0] reg_rdata;
    always_comb begin
        case (req.ofs)
            fwad_pkg::OFS_IDENTITY: reg_rdata = fwad_pkg::IDENTITY_VAL;  // RQ9
            fwad_pkg::OFS_SCRATCH:  reg_rdata = scratch_q;
            fwad_pkg::OFS_DIE_SEL:  reg_rdata = die_sel_q;
            fwad_pkg::OFS_CONFIG:   reg_rdata = cfg_q;
            fwad_pkg::OFS_OUT_CTL:  reg_rdata = out_ctl_q;
            fwad_pkg::OFS_IRQ_CTL:  reg_rdata = irq_ctl_q;
            fwad_pkg::OFS_TOGGLE:   reg_rdata = {5'h00, toggle_q, 2'h0};
            fwad_pkg::OFS_MODE_CTL,
            fwad_pkg::OFS_MODE_CFM: reg_rdata = {3'h0, ctl_q, mode_q}
                                              & ~fwad_pkg::MODE_CTL_RSVD0; // RQ11 RQ12
            // Undefined reserved locations read as zero
            default:                reg_rdata = fwad_pkg::RD_ZERO;  // RQ10
        endcase
    end

    // Boot fetch address: die and byte inside 1KB image
    logic       boot_die;
    logic [9:0] boot_addr;
    always_comb begin
        boot_addr = req.ofs[9:0];                           // Alias twice inside 2KB section RQ3
        boot_die  = 1'b0;                                   // RQ6
        // Only the upper 1KB of section 0 can move to the second die
        if (DUAL_DIE && req.ofs[10] && sec == fwad_pkg::SEC_BOOT_LO
            && (normal || hdi_set_q)) begin
            boot_die = 1'b1;                                // RQ7 RQ8
        end
    end

    // Boot fetch is launched with the read; array data returns next cycle
    logic boot_pend_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            boot <= '0;
            boot_pend_q <= 1'b0;
        end else begin
            boot.en   <= req.rd && is_boot && mode_q != fwad_pkg::MODE_POWERDN; // RQ3
            boot.die  <= boot_die;
            boot.addr <= boot_addr;
            boot_pend_q <= req.rd && is_boot && mode_q != fwad_pkg::MODE_POWERDN;
        end
    end

    // Read answer: register reads one cycle, boot reads two cycles
    // Boot answer wins a clash: a register read taken just after a boot read
    // gets no answer, so the host must leave a cycle after each boot read
    always_ff @(posedge clk) begin
        if (srst) begin
            rsp <= '0;
        end else if (boot_pend_q) begin
            rsp.valid <= 1'b1;
            rsp.data  <= boot_rdata;                        // RQ3
        end else if (req.rd && is_reg && mode_q != fwad_pkg::MODE_POWERDN) begin
            rsp.valid <= 1'b1;
            rsp.data  <= normal ? reg_rdata : fwad_pkg::RD_ZERO; // RQ4 RQ13 RQ5
        end else begin
            // Idle, writes and power-down reads: no answer
            rsp.valid <= 1'b0;
            rsp.data  <= fwad_pkg::RD_ZERO;
        end
    end

    // Mirrored outputs from flip-flops
    // Ports lag the internal state by one cycle, the price of flop outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            mode    <= fwad_pkg::MODE_RESET;
            out_ctl <= fwad_pkg::RST_OUT_CTL;
            irq_ctl <= fwad_pkg::RST_IRQ_CTL;
        end else begin
            mode    <= mode_q;                              // RQ15
            out_ctl <= out_ctl_q;
            irq_ctl <= irq_ctl_q;
        end
    end

    // Assertions
    a_reset_reg_zero: assert property (@(posedge clk) disable iff (srst) // RQ13
        (req.rd && is_reg && mode_q == fwad_pkg::MODE_RESET) |=> rsp.valid && rsp.data == 8'h00)
        else $error("register read in reset mode not zero");
    a_identity_fixed: assert property (@(posedge clk) disable iff (srst) // RQ9
        (req.rd && normal && req.ofs == fwad_pkg::OFS_IDENTITY)
        |=> rsp.data == fwad_pkg::IDENTITY_VAL)
        else $error("identity read wrong");
    a_rsvd_zero_bits: assert property (@(posedge clk) disable iff (srst) // RQ11
        (req.rd && normal && req.ofs == fwad_pkg::OFS_MODE_CTL) |=> rsp.data[7:5] == 3'h0)
        else $error("reserved zero bits not zero");
    a_boot_alias: assert property (@(posedge clk) disable iff (srst) // RQ3
        (req.rd && is_boot && !(DUAL_DIE && (normal || hdi_set_q)) && mode_q != 2'h2)
        |=> boot.en && !boot.die && boot.addr == $past(req.ofs[9:0]))
        else $error("boot alias wrong");
    a_dual_upper: assert property (@(posedge clk) disable iff (srst) // RQ8
        (DUAL_DIE && normal && req.rd && sec == 2'h0 && req.ofs[10]) |=> boot.die)
        else $error("second die not in section zero");
    a_sec3_first: assert property (@(posedge clk) disable iff (srst) // RQ6
        (req.rd && sec == 2'h3 && mode_q != 2'h2) |=> boot.en && !boot.die)
        else $error("section three not first die");
    a_scratch_store: assert property (@(posedge clk) disable iff (srst) // RQ5
        (wr_reg && req.ofs == fwad_pkg::OFS_SCRATCH && !leave_reset)
        |=> scratch_q == $past(req.wdata))
        else $error("scratch not stored");
    a_mode_change: assert property (@(posedge clk) disable iff (srst) // RQ16
        (!$past(srst) && mode_q != $past(mode_q))
        |-> $past(req.wr && req.ofs == fwad_pkg::OFS_MODE_CFM && pend_q))
        else $error("mode changed without confirmation");
    a_leave_values: assert property (@(posedge clk) disable iff (srst) // RQ14
        leave_reset |=> scratch_q == 8'h00 && cfg_q == 8'h00)
        else $error("reset values not applied");

    // Boot read in two steps: taken, fetch raised, then the answer
    sequence s_boot_take;
        req.rd && is_boot && mode_q != fwad_pkg::MODE_POWERDN;
    endsequence
    sequence s_boot_return;
        boot.en ##1 (rsp.valid && rsp.data == $past(boot_rdata));
    endsequence
    a_boot_answer: assert property (@(posedge clk) disable iff (srst) // RQ3
        s_boot_take |=> s_boot_return)
        else $error("boot read answer wrong");

    // Mode change in steps: value, one quiet cycle, then the complement
    sequence s_arm_normal;
        req.wr && req.ofs == fwad_pkg::OFS_MODE_CTL && req.wdata == 8'h05;
    endsequence
    sequence s_confirm_normal;
        req.wr && req.ofs == fwad_pkg::OFS_MODE_CFM && req.wdata == 8'hFA;
    endsequence
    a_enter_normal: assert property (@(posedge clk) disable iff (srst) // RQ16
        s_arm_normal ##1 (!req.wr && !req.rd) ##1 s_confirm_normal
        |=> mode_q == fwad_pkg::MODE_NORMAL)
        else $error("mode sequence did not reach normal");

    // Register answers come one cycle after the read, unless a boot answer is due
    a_reg_answer: assert property (@(posedge clk) disable iff (srst) // RQ5
        (req.rd && is_reg && normal && !boot_pend_q)
        |=> rsp.valid && rsp.data == $past(reg_rdata))
        else $error("register read answer wrong");
    // Power-down answers nothing and fetches nothing
    a_power_quiet: assert property (@(posedge clk) disable iff (srst) // RQ15
        (req.rd && mode_q == fwad_pkg::MODE_POWERDN && !boot_pend_q)
        |=> !rsp.valid && !boot.en)
        else $error("power-down read answered");
    // Any write to the configuration offset arms the second boot image
    a_hdi_flag: assert property (@(posedge clk) disable iff (srst) // RQ7
        (req.wr && req.ofs == fwad_pkg::OFS_CONFIG) |=> hdi_set_q)
        else $error("die index write not seen");
    // The mode port follows the internal mode one cycle later
    a_mode_port: assert property (@(posedge clk) disable iff (srst) // RQ15
        !srst |=> mode == $past(mode_q))
        else $error("mode port out of step");
endmodule

`default_nettype wire

/* dv/fwad_host_model.sv */
// Host processor model issuing byte cycles into the decoder window
`timescale 1ns/1ps
`default_nettype none

module fwad_host_model (
    input  wire fwad_pkg::fwad_rsp_t rsp_a,                 // Answer of the single-die device
    input  wire fwad_pkg::fwad_rsp_t rsp_b,                 // Answer of the dual-die device
    input  wire logic                clk,
    output var  fwad_pkg::fwad_req_t req
);
    // Quiet bus at time zero
    initial req = '0;

    // Release: strobes low, stale offset and data inverted so they never look current
    task automatic drop();
        req.rd    <= 1'h0;
        req.wr    <= 1'h0;
        req.ofs   <= ~req.ofs;
        req.wdata <= ~req.wdata;
    endtask

    // One write cycle; the strobe is sampled at exactly one edge
    task automatic wr(input logic [12:0] ofs, input logic [7:0] d);
        @(posedge clk);
        req <= '{rd: 1'h0, wr: 1'h1, ofs: ofs, wdata: d};
        @(posedge clk);
        drop();
    endtask

    // One read cycle; bounded wait, since power-down never answers
    task automatic rd(input logic [12:0] ofs, output logic [7:0] da, output logic [7:0] db,
                      output logic ok);
        // Unknown until answered, so a missing answer never matches
        da = 8'hXX;
        db = 8'hXX;
        ok = 1'h0;
        @(posedge clk);
        req <= '{rd: 1'h1, wr: 1'h0, ofs: ofs, wdata: 8'h00};
        @(posedge clk);
        drop();
        for (int i = 0; i < 4; i++) begin
            #1;
            // Answers stand one cycle, so each cycle is looked at
            if (rsp_a.valid === 1'h1) begin
                da = rsp_a.data;
                ok = 1'h1;
            end
            if (rsp_b.valid === 1'h1) begin
                db = rsp_b.data;
            end
            @(posedge clk);
        end
    endtask

    // Mode change: value with write enable set and top bits zero, then its complement
    task automatic set_mode(input logic [1:0] m);
        wr(fwad_pkg::OFS_MODE_CTL, {6'h01, m});
        wr(fwad_pkg::OFS_MODE_CFM, ~{6'h01, m});
    endtask
endmodule

`default_nettype wire

/* dv/flash_window_address_decoder_test.sv */
// Self-checking bench for the flash window address decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module flash_window_address_decoder_test;
    typedef struct {
        logic [1:0]  k;                                     // 0 read, 1 write, 2 mode change
        logic [12:0] ofs;
        logic [7:0]  d;
        logic [7:0]  ea;                                    // Expected, single die
        logic [7:0]  eb;                                    // Expected, dual die
    } fwad_row_t;
    logic                 clk;
    logic                 srst;
    fwad_pkg::fwad_req_t  req;
    fwad_pkg::fwad_rsp_t  rsp_a, rsp_b;
    fwad_pkg::fwad_boot_t boot_a, boot_b;
    logic [7:0]           brd_a, brd_b, pat_q, out_a, irq_a;
    logic [1:0]           mode_a, mode_b;
    fwad_row_t            rows[$];
    int                   n_fail, compares;

    // Boot image pattern; die and upper address bits both show in the byte
    function automatic logic [7:0] img(input logic die, input logic [9:0] a);
        return a[7:0] ^ {a[9:8], die, 5'h0A};
    endfunction

    // Flash array: byte only while a fetch is up, a changing pattern otherwise
    always @(posedge clk) pat_q <= srst ? 8'h00 : ~pat_q;
    assign brd_a = boot_a.en ? img(boot_a.die, boot_a.addr) : pat_q;
    assign brd_b = boot_b.en ? img(boot_b.die, boot_b.addr) : pat_q;

    fwad_decoder #(.DUAL_DIE(1'h0)) dut_u (.clk(clk), .srst(srst), .req(req),
        .boot_rdata(brd_a), .rsp(rsp_a), .boot(boot_a), .mode(mode_a), .out_ctl(out_a),
        .irq_ctl(irq_a));
    // Dual-die build sees the very same host cycles
    fwad_decoder #(.DUAL_DIE(1'h1)) dut2_u (.clk(clk), .srst(srst), .req(req),
        .boot_rdata(brd_b), .rsp(rsp_b), .boot(boot_b), .mode(mode_b), .out_ctl(),
        .irq_ctl());
    fwad_host_model host_u (.rsp_a(rsp_a), .rsp_b(rsp_b), .clk(clk), .req(req));

    // Clock, 20 ns period
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Watchdog, well above the expected run length
    initial begin
        #(20 * 3000);
        n_fail++;
        summarize();
    end

    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic row(input logic [1:0] k, input logic [12:0] o, input logic [7:0] d,
                       input logic [7:0] ea, input logic [7:0] eb);
        rows.push_back('{k, o, d, ea, eb});
    endtask

    initial begin
        logic [7:0] da, db;
        logic       ok;
        srst = 1'h1;
        n_fail = 0;
        compares = 0;
        row(2'h0, 13'h1000, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h1004, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h0800, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h17FF, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h0005, 8'h00, img(1'h0, 10'h005), img(1'h0, 10'h005));
        row(2'h0, 13'h07FF, 8'h00, img(1'h0, 10'h3FF), img(1'h0, 10'h3FF));
        row(2'h0, 13'h1C05, 8'h00, img(1'h0, 10'h005), img(1'h0, 10'h005));
        row(2'h0, 13'h0405, 8'h00, img(1'h0, 10'h005), img(1'h0, 10'h005));
        row(2'h1, 13'h100A, 8'h10, 8'h00, 8'h00);
        row(2'h0, 13'h0405, 8'h00, img(1'h0, 10'h005), img(1'h1, 10'h005));
        row(2'h2, 13'h0000, 8'h01, 8'h00, 8'h00);
        row(2'h0, 13'h100A, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h1004, 8'h00, 8'h00, 8'h00);
        row(2'h1, 13'h1000, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h1000, 8'h00, fwad_pkg::IDENTITY_VAL, fwad_pkg::IDENTITY_VAL);
        row(2'h1, 13'h1004, 8'h5A, 8'h00, 8'h00);
        row(2'h0, 13'h1004, 8'h00, 8'h5A, 8'h5A);
        row(2'h1, 13'h100C, 8'h3C, 8'h00, 8'h00);
        row(2'h1, 13'h100E, 8'h81, 8'h00, 8'h00);
        row(2'h1, 13'h1010, 8'hFF, 8'h00, 8'h00);
        row(2'h0, 13'h1010, 8'h00, 8'h00, 8'h00);
        // Control word after leaving reset: reset value with mode normal
        row(2'h0, 13'h1006, 8'h00, fwad_pkg::RST_MODE_CTL | 8'h01,
            fwad_pkg::RST_MODE_CTL | 8'h01);
        // Toggle shows its old state, then flips
        row(2'h0, 13'h1046, 8'h00, 8'h00, 8'h00);
        row(2'h0, 13'h1046, 8'h00, 8'h04, 8'h04);
        row(2'h0, 13'h0405, 8'h00, img(1'h0, 10'h005), img(1'h1, 10'h005));
        row(2'h0, 13'h1C05, 8'h00, img(1'h0, 10'h005), img(1'h0, 10'h005));
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        foreach (rows[i]) begin
            case (rows[i].k)
                2'h0: begin
                    host_u.rd(rows[i].ofs, da, db, ok);
                    `CHK(da, rows[i].ea)
                    `CHK(db, rows[i].eb)
                end
                2'h1: host_u.wr(rows[i].ofs, rows[i].d);
                default: host_u.set_mode(rows[i].d[1:0]);
            endcase
        end
        repeat (2) @(posedge clk);
        #1;
        `CHK(mode_a, fwad_pkg::MODE_NORMAL)
        `CHK(out_a, 8'h3C)
        `CHK(irq_a, 8'h81)
        // A write between the two halves cancels the change
        host_u.wr(fwad_pkg::OFS_MODE_CTL, 8'h06);
        host_u.wr(fwad_pkg::OFS_SCRATCH, 8'h11);
        host_u.wr(fwad_pkg::OFS_MODE_CFM, 8'hF9);
        repeat (2) @(posedge clk);
        #1;
        `CHK(mode_a, fwad_pkg::MODE_NORMAL)
        host_u.set_mode(fwad_pkg::MODE_POWERDN);
        repeat (2) @(posedge clk);
        #1;
        `CHK(mode_b, fwad_pkg::MODE_POWERDN)
        host_u.rd(fwad_pkg::OFS_IDENTITY, da, db, ok);
        `CHK(ok, 1'h0)
        // Second reset mid-run brings back reset mode
        srst <= 1'h1;
        @(posedge clk);
        srst <= 1'h0;
        host_u.rd(fwad_pkg::OFS_IDENTITY, da, db, ok);
        `CHK(da, 8'h00)
        `CHK(mode_a, fwad_pkg::MODE_RESET)
        summarize();
    end
endmodule

`default_nettype wire
